// file: verilog/cfxp_pkg.sv
// Constants and types for the CPU frame extraction port.
package cfxp_pkg;
  localparam int        NQ           = 2;
  localparam int        NG           = 2;
  localparam int        DEPTH_LOG2   = 6;
  localparam logic [7:0] PRUNE_OFS   = 8'h00;
  localparam logic [7:0] GRPCFG_OFS  = 8'h08;
  localparam logic [7:0] MAP_OFS     = 8'h10;
  localparam logic [7:0] RD_OFS      = 8'h18;
  localparam logic [7:0] FLUSH_OFS   = 8'h28;
  localparam logic [7:0] PEND_OFS    = 8'h2c;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h40;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h44;
  localparam logic [7:0] INST_STEP   = 8'h04;
  localparam int        SWAP_BIT     = 0;
  localparam int        STPOS_BIT    = 1;
  localparam int        GRPSEL_BIT   = 4;
  localparam int        MAPEN_BIT    = 0;
  localparam int        QPEND_LSB    = 2;
  localparam logic [1:0] GRPCFG_RST  = 2'h3;
  localparam logic [7:0] PRUNE_RST   = 8'h00;
  localparam logic [31:0] MARK_BASE  = 32'h80000000;
  localparam logic [2:0] MARK_TRUNC  = 3'h4;
  localparam logic [2:0] MARK_ABORT  = 3'h5;
  localparam logic [2:0] MARK_ESC    = 3'h6;
  localparam logic [2:0] MARK_NRDY   = 3'h7;
  typedef enum logic [1:0] {KIND_DATA = 2'h0, KIND_LAST = 2'h1, KIND_STAT = 2'h2} cfxp_kind_t;
  typedef enum logic [3:0] {PH_IDLE = 4'h1, PH_FRAME = 4'h2, PH_ESC = 4'h4, PH_EOF = 4'h8} cfxp_phase_t;
endpackage : cfxp_pkg

// file: verilog/cfxp_top.sv
// CPU frame extraction port: two CPU queues drained by two read groups.
`timescale 1ns/1ps
`default_nettype none
module cfxp_top (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire logic [cfxp_pkg::NQ-1:0]    in_valid,
  input  wire logic [cfxp_pkg::NQ-1:0][31:0] in_data,
  input  wire logic [cfxp_pkg::NQ-1:0][1:0]  in_kind,
  input  wire logic [cfxp_pkg::NQ-1:0][1:0]  in_unused,
  input  wire logic [cfxp_pkg::NQ-1:0]    in_abort,
  output logic      [cfxp_pkg::NQ-1:0]    in_ready,
  output logic                            irq
);
  import cfxp_pkg::*;

  localparam int EW = 37;
  localparam int PW = DEPTH_LOG2 + 1;

  // Byte reversal between network order and little-endian.
  function automatic logic [31:0] swap_bytes(input logic [31:0] w);
    swap_bytes = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : swap_bytes

  // True when a word would be taken by software for a marker.
  function automatic logic is_mark(input logic [31:0] w);
    is_mark = (w[31:3] == MARK_BASE[31:3]);
  endfunction : is_mark

  logic              rst_s1;
  logic              rst_n;
  logic [7:0]        prune [NQ];
  logic [1:0]        grpcfg [NG];
  logic [NQ-1:0]     map_grp;
  logic [NQ-1:0]     map_en;
  logic [3:0]        irq_stat;
  logic [3:0]        irq_mask;
  logic [EW-1:0]     mem [NQ][2**DEPTH_LOG2];
  logic [PW-1:0]     wr_ptr [NQ];
  logic [PW-1:0]     rd_ptr [NQ];
  logic [PW-1:0]     level [NQ];
  logic [NQ-1:0]     skip;
  logic [NQ-1:0]     push;
  logic [NQ-1:0]     flush;
  logic [NQ-1:0]     skip_pop;
  logic [NQ-1:0]     qpend;
  logic [NG-1:0]     gpend;
  cfxp_phase_t       ph [NG];
  logic [NG-1:0]     cur_q;
  logic [8:0]        wcnt [NG];
  logic [31:0]       esc_word [NG];
  logic [NG-1:0]     esc_eof;
  logic [NG-1:0]     swp;
  logic [2:0]        eof_code [NG];
  cfxp_phase_t       next_ph [NG];
  logic [NG-1:0]     next_cur_q;
  logic [8:0]        next_wcnt [NG];
  logic [31:0]       next_esc_word [NG];
  logic [NG-1:0]     next_esc_eof;
  logic [NG-1:0]     next_swp;
  logic [2:0]        next_eof_code [NG];
  logic [31:0]       port_word [NG];
  logic [1:0]        pop_n [NQ];
  logic [NQ-1:0]     set_skip;
  logic [31:0]       next_rdata;

  // Reset release through two flip-flops.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NQ; i++) begin
        prune[i] <= PRUNE_RST;
      end
      for (int i = 0; i < NG; i++) begin
        grpcfg[i] <= GRPCFG_RST;
      end
      map_grp  <= '0;
      map_en   <= '0;
      irq_mask <= 4'h0;
    end else if (reg_wr) begin
      for (int i = 0; i < 2; i++) begin
        if (reg_addr == PRUNE_OFS + INST_STEP * 8'(i)) begin
          prune[i] <= reg_wdata[7:0];
        end
        if (reg_addr == GRPCFG_OFS + INST_STEP * 8'(i)) begin
          grpcfg[i] <= reg_wdata[1:0];
        end
        if (reg_addr == MAP_OFS + INST_STEP * 8'(i)) begin
          map_grp[i] <= reg_wdata[GRPSEL_BIT];
          map_en[i]  <= reg_wdata[MAPEN_BIT];
        end
      end
      if (reg_addr == IRQ_MSK_OFS) begin
        irq_mask <= reg_wdata[3:0];
      end
    end
  end

  // Flush is a one-shot write; the bit reads back as zero.
  assign flush = (reg_wr && reg_addr == FLUSH_OFS) ? reg_wdata[NQ-1:0] : '0;

  // Queue storage and pointers.
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      level[q]    = wr_ptr[q] - rd_ptr[q];
      in_ready[q] = (level[q] != PW'(2**DEPTH_LOG2));
      push[q]     = in_valid[q] && in_ready[q];
      skip_pop[q] = skip[q] && (level[q] != '0);
    end
  end

  always_ff @(posedge core_clk) begin
    for (int q = 0; q < NQ; q++) begin
      if (push[q]) begin
        mem[q][wr_ptr[q][DEPTH_LOG2-1:0]] <= {in_abort[q], in_unused[q], in_kind[q], in_data[q]};
      end
    end
  end

  // Pointers advance on pushes, group pops and discard of pruned tails.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int q = 0; q < NQ; q++) begin
        wr_ptr[q] <= '0;
        rd_ptr[q] <= '0;
      end
      skip <= '0;
    end else begin
      for (int q = 0; q < NQ; q++) begin
        if (flush[q]) begin
          wr_ptr[q] <= '0;
          rd_ptr[q] <= '0;
          skip[q]   <= 1'b0;
        end else begin
          wr_ptr[q] <= wr_ptr[q] + PW'(push[q]);
          rd_ptr[q] <= rd_ptr[q] + PW'(pop_n[q]) + PW'(skip_pop[q]);
          if (set_skip[q]) begin
            skip[q] <= 1'b1;
          end else if (skip_pop[q] && mem[q][rd_ptr[q][DEPTH_LOG2-1:0]][33:32] == KIND_STAT) begin
            skip[q] <= 1'b0;
          end
        end
      end
    end
  end

  // Read port behaviour of each group, decided for the current strobe.
  always_comb begin
    logic          hit;
    logic          found;
    logic          qs;
    logic          eof;
    logic          ok;
    logic [EW-1:0] e0;
    logic [EW-1:0] e1;
    logic [EW-1:0] ent;
    logic [31:0]   out;
    hit = 1'b0;
    found = 1'b0;
    qs = 1'b0;
    eof = 1'b0;
    ok = 1'b0;
    e0 = '0;
    e1 = '0;
    ent = '0;
    out = '0;
    for (int q = 0; q < NQ; q++) begin
      pop_n[q] = 2'h0;
    end
    set_skip = '0;
    for (int g = 0; g < NG; g++) begin
      next_ph[g]       = ph[g];
      next_cur_q[g]    = cur_q[g];
      next_wcnt[g]     = wcnt[g];
      next_esc_word[g] = esc_word[g];
      next_esc_eof[g]  = esc_eof[g];
      next_swp[g]      = swp[g];
      next_eof_code[g] = eof_code[g];
      port_word[g]     = MARK_BASE | 32'(MARK_NRDY);
      hit = reg_rd && (reg_addr == RD_OFS + INST_STEP * 8'(g));
      // A new frame is only picked at a boundary, so map changes wait for it.
      found = 1'b0;
      qs = cur_q[g];
      if (ph[g] == PH_IDLE) begin
        for (int q = NQ - 1; q >= 0; q--) begin
          if (map_en[q] && map_grp[q] == 1'(g) && !skip[q] && level[q] != '0) begin
            found = 1'b1;
            qs = 1'(q);
          end
        end
      end else begin
        found = 1'b1;
      end
      e0 = mem[qs][rd_ptr[qs][DEPTH_LOG2-1:0]];
      e1 = mem[qs][DEPTH_LOG2'(rd_ptr[qs][DEPTH_LOG2-1:0] + 1'b1)];
      ok = 1'b0;
      eof = 1'b0;
      out = '0;
      if (hit) begin
        unique case (ph[g])
          PH_ESC: begin
            port_word[g] = esc_word[g];
            next_ph[g] = esc_eof[g] ? PH_EOF : PH_FRAME;
          end
          PH_EOF: begin
            port_word[g] = MARK_BASE | 32'(eof_code[g]);
            next_ph[g] = PH_IDLE;
          end
          PH_IDLE, PH_FRAME: begin
            if (found && level[qs] != '0) begin
              // A frame that fits the limit exactly ends with its status, not with truncation.
              if (prune[qs] != 8'h00 && wcnt[g] == {1'b0, prune[qs]} + 9'h001 && e0[33:32] != KIND_STAT) begin
                port_word[g] = MARK_BASE | 32'(MARK_TRUNC);
                set_skip[qs] = 1'b1;
                next_ph[g] = PH_IDLE;
              end else if (e0[33:32] == KIND_LAST && !grpcfg[g][STPOS_BIT]) begin
                // Status goes out first, then the held last data word.
                if (level[qs] > PW'(1)) begin
                  ok = 1'b1;
                  ent = swp[g] ? e0 : e1;
                  eof = swp[g];
                  pop_n[qs] = swp[g] ? 2'h2 : 2'h0;
                  next_swp[g] = !swp[g];
                  if (!swp[g]) begin
                    next_eof_code[g] = e1[36] ? MARK_ABORT : {1'b0, e1[35:34]};
                  end
                end
              end else begin
                ok = 1'b1;
                ent = e0;
                pop_n[qs] = 2'h1;
                eof = (e0[33:32] == KIND_STAT);
                if (eof) begin
                  next_eof_code[g] = e0[36] ? MARK_ABORT : {1'b0, e0[35:34]};
                end
              end
              if (ok) begin
                out = grpcfg[g][SWAP_BIT] ? swap_bytes(ent[31:0]) : ent[31:0];
                next_cur_q[g] = qs;
                next_wcnt[g] = wcnt[g] + 9'(ent[33:32] != KIND_STAT);
                if (is_mark(out)) begin
                  port_word[g] = MARK_BASE | 32'(MARK_ESC);
                  next_esc_word[g] = out;
                  next_esc_eof[g] = eof;
                  next_ph[g] = PH_ESC;
                end else begin
                  port_word[g] = out;
                  next_ph[g] = eof ? PH_EOF : PH_FRAME;
                end
              end
            end
          end
          default: begin
            next_ph[g] = PH_IDLE;
          end
        endcase
      end
      // Flushing the active queue ends the frame in progress.
      if (ph[g] != PH_IDLE && flush[cur_q[g]]) begin
        next_ph[g] = PH_IDLE;
      end
      if (next_ph[g] == PH_IDLE) begin
        next_wcnt[g] = 9'h000;
        next_swp[g] = 1'b0;
      end
    end
  end

  // Group extraction state.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < NG; g++) begin
        ph[g]       <= PH_IDLE;
        wcnt[g]     <= 9'h000;
        esc_word[g] <= 32'h00000000;
        eof_code[g] <= 3'h0;
      end
      cur_q   <= '0;
      esc_eof <= '0;
      swp     <= '0;
    end else begin
      for (int g = 0; g < NG; g++) begin
        ph[g]       <= next_ph[g];
        wcnt[g]     <= next_wcnt[g];
        esc_word[g] <= next_esc_word[g];
        eof_code[g] <= next_eof_code[g];
      end
      cur_q   <= next_cur_q;
      esc_eof <= next_esc_eof;
      swp     <= next_swp;
    end
  end

  // Data-present flags per queue and per group.
  always_comb begin
    for (int q = 0; q < NQ; q++) begin
      qpend[q] = map_en[q] && (level[q] != '0);
    end
    for (int g = 0; g < NG; g++) begin
      gpend[g] = (ph[g] != PH_IDLE);
      for (int q = 0; q < NQ; q++) begin
        if (qpend[q] && map_grp[q] == 1'(g)) begin
          gpend[g] = 1'b1;
        end
      end
    end
  end

  // Sticky events: frame complete in bits 1:0, overflow in bits 3:2; write one clears.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 4'h0;
    end else begin
      for (int q = 0; q < NQ; q++) begin
        if (push[q] && in_kind[q] == KIND_STAT) begin
          irq_stat[q] <= 1'b1;
        end else if (reg_wr && reg_addr == IRQ_ST_OFS && reg_wdata[q]) begin
          irq_stat[q] <= 1'b0;
        end
        if (in_valid[q] && !in_ready[q]) begin
          irq_stat[q+2] <= 1'b1;
        end else if (reg_wr && reg_addr == IRQ_ST_OFS && reg_wdata[q+2]) begin
          irq_stat[q+2] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read-back multiplexer; unmapped addresses read zero.
  always_comb begin
    next_rdata = 32'h00000000;
    for (int i = 0; i < 2; i++) begin
      if (reg_addr == PRUNE_OFS + INST_STEP * 8'(i)) begin
        next_rdata = {24'h000000, prune[i]};
      end
      if (reg_addr == GRPCFG_OFS + INST_STEP * 8'(i)) begin
        next_rdata = {30'h00000000, grpcfg[i]};
      end
      if (reg_addr == MAP_OFS + INST_STEP * 8'(i)) begin
        next_rdata = {27'h0000000, map_grp[i], 3'h0, map_en[i]};
      end
      if (reg_addr == RD_OFS + INST_STEP * 8'(i)) begin
        next_rdata = port_word[i];
      end
    end
    if (reg_addr == PEND_OFS) begin
      next_rdata = {28'h0000000, qpend, gpend};
    end
    if (reg_addr == IRQ_ST_OFS) begin
      next_rdata = {28'h0000000, irq_stat};
    end
    if (reg_addr == IRQ_MSK_OFS) begin
      next_rdata = {28'h0000000, irq_mask};
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
    end
  end
endmodule : cfxp_top
`default_nettype wire

// file: tb/cfxp_chk.sv
// Checker of register port timing and field layout of the extraction port.
`timescale 1ns/1ps
`default_nettype none
module cfxp_chk
  import cfxp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Single accesses at one byte address.
  sequence rd_at(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data seen outside a read answer");
  flush_zero_a: assert property (rd_at(FLUSH_OFS) |=> reg_rdata == 32'h0)
    else $error("flush register did not read zero");
  hole_zero_a: assert property (rd_at(8'h30) |=> reg_rdata == 32'h0)
    else $error("unmapped address did not read zero");
  prune_echo_a: assert property (wr_at(PRUNE_OFS) ##1 !reg_wr ##1 rd_at(PRUNE_OFS) |=>
    reg_rdata == {24'h0, $past(reg_wdata[7:0], 3)}) else $error("prune value not read back");
  cfg_bits_a: assert property (reg_rd && reg_addr[7:3] == 5'h01 |=> reg_rdata[31:2] == 30'h0)
    else $error("group format reserved bits set");
  map_bits_a: assert property (reg_rd && reg_addr[7:3] == 5'h02 |=> (reg_rdata & ~32'h11) == 32'h0)
    else $error("queue map reserved bits set");
  pend_group_a: assert property (rd_at(PEND_OFS) |=> reg_rdata[31:4] == 28'h0 &&
    (reg_rdata[3:2] == 2'h0 || reg_rdata[1:0] != 2'h0)) else $error("queue pending without group pending");
  irq_mask_a: assert property (reg_wr && reg_addr == IRQ_MSK_OFS && reg_wdata == 32'h0 |=> !irq)
    else $error("interrupt high with all sources masked");
endmodule : cfxp_chk
bind cfxp_top cfxp_chk i_chk (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

// file: tb/cfxp_feeder.sv
// Feeder model that pushes frames into one CPU queue of the extraction port.
`timescale 1ns/1ps
`default_nettype none
module cfxp_feeder (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        go,
  input  wire logic        slow,
  input  wire logic [7:0]  nwords,
  input  wire logic [31:0] base,
  input  wire logic        ready,
  output logic             valid,
  output logic [31:0]      data,
  output logic [1:0]       kind,
  output logic             busy
);
  logic [8:0] idx;
  // Entry i of a frame: data words with the last one marked, then the status word.
  function automatic logic [33:0] entry(input logic [8:0] i);
    if (i < 9'(nwords)) begin
      return {(i == 9'(nwords) - 9'h1) ? 2'h1 : 2'h0, base ^ 32'(i)};
    end
    return {2'h2, ~base};
  endfunction : entry
  // Holds an entry until taken; when slow it idles a cycle, and idle data toggles every cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy  <= 1'b0;
      valid <= 1'b0;
      idx   <= 9'h0;
      {kind, data} <= 34'h0;
    end else if (go && !busy) begin
      busy  <= 1'b1;
      valid <= 1'b1;
      idx   <= 9'h0;
      {kind, data} <= entry(9'h0);
    end else if (valid && ready) begin
      idx   <= idx + 9'h1;
      busy  <= idx < 9'(nwords);
      valid <= !slow && idx < 9'(nwords);
      {kind, data} <= (slow || idx >= 9'(nwords)) ? {kind, ~data} : entry(idx + 9'h1);
    end else if (busy && !valid) begin
      valid <= 1'b1;
      {kind, data} <= entry(idx);
    end else if (!valid) begin
      data  <= ~data;
    end
  end
endmodule : cfxp_feeder
`default_nettype wire

// file: tb/tb_cpu_frame_extraction_port.sv
// Self-checking bench of the CPU frame extraction port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_cpu_frame_extraction_port;
  import cfxp_pkg::*;
  logic                core_clk = 1'b0;
  logic                reset_n = 1'b0;
  logic [7:0]          reg_addr = 8'h00;
  logic [31:0]         reg_wdata = 32'h0, reg_rdata, d, seed = 32'h048b, base = 32'h0;
  logic                reg_wr = 1'b0, reg_rd = 1'b0, irq, slow = 1'b0;
  logic [NQ-1:0]       in_valid, in_ready, busy, go = '0, in_abort = '0;
  logic [NQ-1:0][31:0] in_data;
  logic [NQ-1:0][1:0]  in_kind, in_unused = '0;
  logic [7:0]          nw = 8'h03;
  logic [39:0]         rv [11] = '{{PRUNE_OFS, 32'h0}, {8'h04, 32'h0}, {GRPCFG_OFS, 32'h3}, {8'h0c, 32'h3},
    {MAP_OFS, 32'h0}, {8'h14, 32'h0}, {FLUSH_OFS, 32'h0}, {PEND_OFS, 32'h0}, {8'h30, 32'h0},
    {RD_OFS, 32'h80000007}, {8'h1c, 32'h80000007}};
  logic [31:0]         msk [6] = '{32'hff, 32'hff, 32'h3, 32'h3, 32'h11, 32'h11};
  int                  fails = 0, cmp_count = 0, i, t;
  always #12.5 core_clk = ~core_clk;
  cfxp_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_data(in_data),
    .in_kind(in_kind), .in_unused(in_unused), .in_abort(in_abort), .in_ready(in_ready), .irq(irq));
  // One feeder per CPU queue.
  for (genvar q = 0; q < NQ; q++) begin : g_feed
    cfxp_feeder i_feed (.core_clk(core_clk), .reset_n(reset_n), .go(go[q]), .slow(slow), .nwords(nw),
      .base(base), .ready(in_ready[q]), .valid(in_valid[q]), .data(in_data[q]), .kind(in_kind[q]), .busy(busy[q]));
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] fmt(input logic [31:0] w, input logic sw);
    return sw ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction : fmt
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // Starts one frame on a queue and waits, bounded, until the feeder is done.
  task automatic feed(input int q);
    @(posedge core_clk);
    go[q] <= 1'b1;
    @(posedge core_clk);
    go[q] <= 1'b0;
    #1;
    for (int n = 0; busy[q] && n < 300; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (busy[q]) begin
      fails++;
      test_done();
    end
    repeat (3) @(posedge core_clk);
  endtask : feed
  // Reads one expected word, escaped first when it looks like a marker.
  task automatic ew(input logic [7:0] rp, input logic [31:0] w);
    if (w[31:3] == MARK_BASE[31:3]) begin
      rd(rp);
      `CHK(d, MARK_BASE | 32'(MARK_ESC))
    end
    rd(rp);
    `CHK(d, w)
  endtask : ew
  // Sends a frame through queue q and group g and reads it back completely.
  task automatic frame(input int q, g, sw, sp, pr, ab, dis, input logic [1:0] un);
    logic [7:0] rp;
    int         lim;
    rp = RD_OFS + 8'(4 * g);
    lim = (pr != 0 && pr + 1 < nw) ? pr + 1 : nw - 1;
    wr(PRUNE_OFS + 8'(4 * q), 32'(pr));
    wr(GRPCFG_OFS + 8'(4 * g), 32'(sw + 2 * sp));
    wr(MAP_OFS + 8'(4 * q), 32'(16 * g + 1));
    in_unused[q] <= un;
    in_abort[q] <= ab[0];
    feed(q);
    rd(PEND_OFS);
    `CHK(d[3:0], 4'(4 << q | 1 << g))
    for (int k = 0; k < lim; k++) begin
      ew(rp, fmt(base ^ 32'(k), sw[0]));
      if (dis != 0 && k == 0) wr(MAP_OFS + 8'(4 * q), 32'(16 * g));
    end
    if (pr != 0 && pr + 1 < nw) begin
      rd(rp);
      `CHK(d, MARK_BASE | 32'(MARK_TRUNC))
    end else begin
      if (sp == 0) ew(rp, fmt(~base, sw[0]));
      ew(rp, fmt(base ^ 32'(lim), sw[0]));
      if (sp != 0) ew(rp, fmt(~base, sw[0]));
      rd(rp);
      `CHK(d, MARK_BASE | (ab != 0 ? 32'(MARK_ABORT) : 32'(un)))
    end
    rd(rp);
    `CHK(d, MARK_BASE | 32'(MARK_NRDY))
    rd(PEND_OFS);
    `CHK(d[3:0], 4'h0)
  endtask : frame
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(in_ready, 2'h3)
    // Reset values, not-ready answers and an unmapped hole.
    foreach (rv[j]) begin
      rd(rv[j][39:32]);
      `CHK(d, rv[j][31:0])
    end
    $display("test reset values done");
    // Random values written and read back through the field masks.
    for (i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(8'(4 * i), seed);
      rd(8'(4 * i));
      `CHK(d, seed & msk[i])
    end
    wr(8'h30, seed);
    rd(8'h30);
    `CHK(d, 32'h0)
    $display("test register fields done");
    // Random frames over both queues and groups, with escape, abort, disable and prune corners.
    // The last frame has a prune limit that exactly fits it, so it must arrive whole.
    for (t = 0; t < 10; t++) begin
      seed = lfsr(seed);
      nw = (t == 6) ? 8'h03 : 8'(3 + seed[2:0]);
      base = (t == 4) ? 32'h80000002 : {1'b0, seed[30:0]};
      slow <= seed[7];
      frame(t % 2, (t / 2) % 2, (t == 4) ? 0 : seed[3], seed[4],
        (t == 6) ? 1 : (t == 8) ? 255 : (t == 9) ? int'(nw) - 1 : 0,
        t == 5, t == 7, seed[6:5]);
      $display("test frame %0d done", t);
    end
    // Unmapped queue: no pending flag, not-ready reads, interrupt, then flush.
    wr(MAP_OFS, 32'h0);
    wr(IRQ_ST_OFS, 32'hf);
    wr(IRQ_MSK_OFS, 32'h3);
    `CHK(irq, 1'b0)
    feed(0);
    `CHK(irq, 1'b1)
    rd(PEND_OFS);
    `CHK(d[3:0], 4'h0)
    rd(RD_OFS);
    `CHK(d, MARK_BASE | 32'(MARK_NRDY))
    wr(IRQ_MSK_OFS, 32'h0);
    `CHK(irq, 1'b0)
    wr(IRQ_MSK_OFS, 32'h3);
    wr(IRQ_ST_OFS, 32'h1);
    `CHK(irq, 1'b0)
    wr(FLUSH_OFS, 32'h0);
    wr(MAP_OFS, 32'h1);
    rd(PEND_OFS);
    `CHK(d[3:0], 4'h5)
    wr(FLUSH_OFS, 32'h1);
    rd(PEND_OFS);
    `CHK(d[3:0], 4'h0)
    $display("test interrupt and flush done");
    test_done();
  end
endmodule : tb_cpu_frame_extraction_port
`default_nettype wire
